// ===== common/mpbs_map.svh
`ifndef MPBS_MAP_SVH
`define MPBS_MAP_SVH

// ----------------------------------------------------------------
// Register indices on the plain register port
// ----------------------------------------------------------------
`define MPBS_SLOT_BASE 5'h00
`define MPBS_SLOT_LAST 5'h04
`define MPBS_METHOD 5'h05
`define MPBS_TIME_BASE 5'h08
`define MPBS_TIME_LAST 5'h0F
`define MPBS_ZERO_B1 5'h10
`define MPBS_ZERO_B2 5'h11
`define MPBS_STATUS 5'h12

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MPBS_TIME_BANK_BIT 2
`define MPBS_ST_MAIN_BIT 0
`define MPBS_ST_LIVE_BIT 1
`define MPBS_ST_RAMP_BIT 2
`define MPBS_ST_STOP_BIT 3
`define MPBS_ST_TERM_LSB 8

// ----------------------------------------------------------------
// Terminal function codes
// ----------------------------------------------------------------
`define MPBS_FN_SECOND_BANK 8'h08
`define MPBS_FN_ALT_RAMP 8'h09
`define MPBS_FN_LIVE_BANK 8'h53
`define MPBS_METHOD_TERMINAL 2'h0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MPBS_SLOT_RST 8'hFF
`define MPBS_METHOD_RST 2'h0
`define MPBS_TIME_RST 16'h0000
`define MPBS_ZERO_RST 16'h0000

`endif

// ===== common/mpbs_pkg.sv
package mpbs_pkg;
  typedef logic [4:0] mpbs_addr_t;
  typedef logic [15:0] mpbs_data_t;
  typedef logic [7:0] mpbs_func_t;
  typedef logic [4:0] mpbs_term_t;
  // Ramp time slot within one bank
  typedef enum logic [1:0] {
    MPBS_ACC_ONE = 2'b00,
    MPBS_DEC_ONE = 2'b01,
    MPBS_ACC_TWO = 2'b10,
    MPBS_DEC_TWO = 2'b11
  } mpbs_time_sel_t;
endpackage

// ===== core/mpbs_bank_select.sv
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "mpbs_map.svh"

// How it works
// R1: Second-bank terminal on selects second bank
// R2: Second-bank terminal off returns first bank
// R3: Main bank held while running
// R4: Live select swaps immediately while running
// R5: Live swap covers only the limited subset, not the full bank
// R6: Functions assigned only to five slots
// R7: Ramp select on uses second ramp times
// R8: Ramp select off uses first ramp times
// R9: Ramp select mid-ramp changes rate then
// R10: Ramp select needs terminal method 00
// R11: Sync terminal inputs; latch bank on stopped cycle
module mpbs_bank_select (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire mpbs_pkg::mpbs_term_t terminal_in,
  input wire logic drive_stopped,
  input wire mpbs_pkg::mpbs_addr_t reg_addr,
  input wire mpbs_pkg::mpbs_data_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output mpbs_pkg::mpbs_data_t reg_rdata_ff,
  output logic main_bank_sel_ff,
  output logic live_bank_sel_ff,
  output logic alt_ramp_select_ff,
  output mpbs_pkg::mpbs_data_t accel_time_ff,
  output mpbs_pkg::mpbs_data_t decel_time_ff,
  output mpbs_pkg::mpbs_data_t multispeed_zero_freq_ff
);
  import mpbs_pkg::*;

  // ----------------------------------------------------------------
  // Terminal synchroniser
  // ----------------------------------------------------------------
  mpbs_term_t term_sync;

  mpbs_term_sync u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .term_async(terminal_in),
    .term_sync_ff(term_sync)
  );

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  mpbs_func_t slot_ff [5];
  logic [1:0] ramp_switch_method_ff;
  mpbs_data_t time_ff [8];
  mpbs_data_t zero_ff [2];

  // Only the five terminal slots carry functions
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_slot
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          slot_ff[gi] <= `MPBS_SLOT_RST;
        end else if (reg_wr && reg_addr == `MPBS_SLOT_BASE + 5'(gi)) begin
          slot_ff[gi] <= reg_wdata[7:0]; // see R6
        end
      end
    end
    for (gi = 0; gi < 8; gi++) begin : g_time
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          time_ff[gi] <= `MPBS_TIME_RST;
        end else if (reg_wr && reg_addr == `MPBS_TIME_BASE + 5'(gi)) begin
          time_ff[gi] <= reg_wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ramp_switch_method_ff <= `MPBS_METHOD_RST;
      zero_ff[0] <= `MPBS_ZERO_RST;
      zero_ff[1] <= `MPBS_ZERO_RST;
    end else if (reg_wr) begin
      if (reg_addr == `MPBS_METHOD) begin
        ramp_switch_method_ff <= reg_wdata[1:0];
      end
      if (reg_addr == `MPBS_ZERO_B1) begin
        zero_ff[0] <= reg_wdata;
      end
      if (reg_addr == `MPBS_ZERO_B2) begin
        zero_ff[1] <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Function decode over the slots
  // ----------------------------------------------------------------
  logic [4:0] set_hit;
  logic [4:0] live_hit;
  logic [4:0] ramp_hit;
  logic set_act;
  logic live_act;
  logic ramp_act;

  generate
    for (gi = 0; gi < 5; gi++) begin : g_dec
      assign set_hit[gi] = term_sync[gi] &&
                           slot_ff[gi] == `MPBS_FN_SECOND_BANK;
      assign live_hit[gi] = term_sync[gi] &&
                            slot_ff[gi] == `MPBS_FN_LIVE_BANK;
      assign ramp_hit[gi] = term_sync[gi] &&
                            slot_ff[gi] == `MPBS_FN_ALT_RAMP;
    end
  endgenerate

  assign set_act = |set_hit;
  assign live_act = |live_hit;
  // Other switch methods leave the terminal without effect
  assign ramp_act = |ramp_hit &&
    ramp_switch_method_ff == `MPBS_METHOD_TERMINAL; // see R10

  // ----------------------------------------------------------------
  // Bank and ramp selection
  // ----------------------------------------------------------------
  logic nxt_main_bank;
  logic nxt_live_bank;
  logic acc_idx_hi;
  mpbs_time_sel_t acc_sel;
  mpbs_time_sel_t dec_sel;
  mpbs_data_t acc_two_cur;
  mpbs_data_t dec_one_cur;

  always_comb begin
    // Latch follows terminal only in the stopped cycle
    nxt_main_bank = drive_stopped ? set_act : main_bank_sel_ff; // see R3, R11
    // Live select overrides without waiting for a stop
    nxt_live_bank = nxt_main_bank | live_act; // see R4
    acc_idx_hi = nxt_live_bank;
    acc_sel = ramp_act ? MPBS_ACC_TWO : MPBS_ACC_ONE; // see R7, R8
    dec_sel = ramp_act ? MPBS_DEC_TWO : MPBS_DEC_ONE; // see R7, R8
    acc_two_cur = time_ff[{acc_idx_hi, MPBS_ACC_TWO}];
    dec_one_cur = time_ff[{acc_idx_hi, MPBS_DEC_ONE}];
  end

  // Full bank (sources, thermal, motor constants) changes only here
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      main_bank_sel_ff <= 1'b0;
    end else begin
      main_bank_sel_ff <= nxt_main_bank; // see R1, R2
    end
  end

  // Limited subset: ramp times, zero speed, boost, limits, two-stage
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      live_bank_sel_ff <= 1'b0;
      multispeed_zero_freq_ff <= `MPBS_ZERO_RST;
    end else begin
      live_bank_sel_ff <= nxt_live_bank; // see R5
      multispeed_zero_freq_ff <= zero_ff[nxt_live_bank]; // see R5
    end
  end

  // Rate follows the terminal every cycle, so a ramp in flight changes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      alt_ramp_select_ff <= 1'b0;
      accel_time_ff <= `MPBS_TIME_RST;
      decel_time_ff <= `MPBS_TIME_RST;
    end else begin
      alt_ramp_select_ff <= ramp_act; // see R9
      accel_time_ff <= time_ff[{nxt_live_bank, acc_sel}]; // see R7, R8
      decel_time_ff <= time_ff[{nxt_live_bank, dec_sel}]; // see R7, R8
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_ff <= 16'h0000;
    end else if (!reg_rd) begin
      reg_rdata_ff <= 16'h0000;
    end else if (reg_addr <= `MPBS_SLOT_LAST) begin
      reg_rdata_ff <= {8'h00, slot_ff[reg_addr[2:0]]};
    end else if (reg_addr == `MPBS_METHOD) begin
      reg_rdata_ff <= {14'h0000, ramp_switch_method_ff};
    end else if (reg_addr >= `MPBS_TIME_BASE &&
                 reg_addr <= `MPBS_TIME_LAST) begin
      reg_rdata_ff <= time_ff[reg_addr[2:0]];
    end else if (reg_addr == `MPBS_ZERO_B1) begin
      reg_rdata_ff <= zero_ff[0];
    end else if (reg_addr == `MPBS_ZERO_B2) begin
      reg_rdata_ff <= zero_ff[1];
    end else if (reg_addr == `MPBS_STATUS) begin
      reg_rdata_ff <= {3'h0, term_sync, 4'h0, drive_stopped,
                       alt_ramp_select_ff, live_bank_sel_ff,
                       main_bank_sel_ff};
    end else begin
      reg_rdata_ff <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_r1_select_second;
    @(posedge core_clk) disable iff (!rst_n)
      drive_stopped && set_act |=> main_bank_sel_ff && live_bank_sel_ff;
  endproperty
  a_r1_select_second: assert property (p_r1_select_second) // see R1
    else $error("second bank not taken while stopped");

  property p_r2_return_first;
    @(posedge core_clk) disable iff (!rst_n)
      drive_stopped && !set_act && !live_act |=>
        !main_bank_sel_ff && !live_bank_sel_ff;
  endproperty
  a_r2_return_first: assert property (p_r2_return_first) // see R2
    else $error("first bank not restored while stopped");

  property p_r3_hold_running;
    @(posedge core_clk) disable iff (!rst_n)
      !drive_stopped[*2] |-> $stable(main_bank_sel_ff);
  endproperty
  a_r3_hold_running: assert property (p_r3_hold_running) // see R3
    else $error("main bank changed while running");

  property p_r4_live_now;
    @(posedge core_clk) disable iff (!rst_n)
      live_act |=> live_bank_sel_ff;
  endproperty
  a_r4_live_now: assert property (p_r4_live_now) // see R4
    else $error("live select did not switch next cycle");

  property p_r5_subset_only;
    @(posedge core_clk) disable iff (!rst_n)
      live_act && !drive_stopped |=>
        main_bank_sel_ff == $past(main_bank_sel_ff) &&
        multispeed_zero_freq_ff == $past(zero_ff[1]);
  endproperty
  a_r5_subset_only: assert property (p_r5_subset_only) // see R5
    else $error("live select touched the full bank");

  property p_r7_second_ramp;
    @(posedge core_clk) disable iff (!rst_n)
      ramp_act |=> alt_ramp_select_ff && accel_time_ff == $past(acc_two_cur);
  endproperty
  a_r7_second_ramp: assert property (p_r7_second_ramp) // see R7
    else $error("second ramp times not used");

  property p_r8_first_ramp;
    @(posedge core_clk) disable iff (!rst_n)
      !ramp_act |=> !alt_ramp_select_ff &&
        decel_time_ff == $past(dec_one_cur);
  endproperty
  a_r8_first_ramp: assert property (p_r8_first_ramp) // see R8
    else $error("first ramp times not restored");

  property p_r9_mid_ramp;
    @(posedge core_clk) disable iff (!rst_n)
      !drive_stopped && $rose(ramp_act) |=> $rose(alt_ramp_select_ff);
  endproperty
  a_r9_mid_ramp: assert property (p_r9_mid_ramp) // see R9
    else $error("ramp rate did not change while running");

  property p_r10_method_gate;
    @(posedge core_clk) disable iff (!rst_n)
      ramp_switch_method_ff != `MPBS_METHOD_TERMINAL |=> !alt_ramp_select_ff;
  endproperty
  a_r10_method_gate: assert property (p_r10_method_gate) // see R10
    else $error("ramp select acted under another method");

  property p_r11_latch_cycle;
    @(posedge core_clk) disable iff (!rst_n)
      drive_stopped && set_act != main_bank_sel_ff |=>
        main_bank_sel_ff != $past(main_bank_sel_ff);
  endproperty
  a_r11_latch_cycle: assert property (p_r11_latch_cycle) // see R11
    else $error("bank not latched in the stopped cycle");

  c_bank_switch: cover property (@(posedge core_clk) disable iff (!rst_n)
    drive_stopped && set_act && !main_bank_sel_ff);
  c_live_running: cover property (@(posedge core_clk) disable iff (!rst_n)
    !drive_stopped && live_act && !live_bank_sel_ff);
  c_ramp_running: cover property (@(posedge core_clk) disable iff (!rst_n)
    !drive_stopped && $rose(ramp_act));
endmodule // mpbs_bank_select

// ===== core/mpbs_term_sync.sv
`timescale 1ns/1ps
module mpbs_term_sync (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire mpbs_pkg::mpbs_term_t term_async,
  output mpbs_pkg::mpbs_term_t term_sync_ff
);
  import mpbs_pkg::*;

  mpbs_term_t meta_ff;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 5'h00;
      term_sync_ff <= 5'h00;
    end else begin
      meta_ff <= term_async;
      term_sync_ff <= meta_ff;
    end
  end
endmodule // mpbs_term_sync

// ===== verif/mpbs_bank_select_bench.sv
`timescale 1ns/1ps
module mpbs_bank_select_bench;
  import mpbs_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  mpbs_term_t want_term = 5'h00;
  logic want_stop = 1'b1;
  mpbs_term_t terminal_in;
  logic drive_stopped;
  mpbs_addr_t reg_addr = 5'h00;
  mpbs_data_t reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  mpbs_data_t reg_rdata_ff, accel_time_ff, decel_time_ff, zero_ff;
  logic main_bank_sel_ff, live_bank_sel_ff, alt_ramp_select_ff;
  int fails = 0;
  int cmp_count = 0;

  mpbs_switch_model i_mpbs_switch_model (
    .core_clk(core_clk), .want_term(want_term), .want_stop(want_stop),
    .terminal_in(terminal_in), .drive_stopped(drive_stopped));

  mpbs_bank_select i_mpbs_bank_select (
    .core_clk(core_clk), .rst_n(rst_n), .terminal_in(terminal_in),
    .drive_stopped(drive_stopped), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_ff(reg_rdata_ff), .main_bank_sel_ff(main_bank_sel_ff),
    .live_bank_sel_ff(live_bank_sel_ff),
    .alt_ramp_select_ff(alt_ramp_select_ff),
    .accel_time_ff(accel_time_ff), .decel_time_ff(decel_time_ff),
    .multispeed_zero_freq_ff(zero_ff));

  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input mpbs_data_t seen,
                     input mpbs_data_t exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input mpbs_addr_t a, input mpbs_data_t d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Data stands one cycle only, then drops to zero
  task automatic rd(input mpbs_addr_t a, input mpbs_data_t exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata_ff, exp);
    @(posedge core_clk);
    #1 chk("rdata idle", reg_rdata_ff, 16'h0000);
  endtask

  // Two syncer flops plus output flop plus model delay
  task automatic set_in(input mpbs_term_t t, input logic s);
    @(posedge core_clk);
    want_term <= t;
    want_stop <= s;
    repeat (5) @(posedge core_clk);
    #1;
  endtask

  // Flag expectations as plain 0 or 1, widened on purpose
  task automatic outs(input int m, input int l, input int r,
                      input mpbs_data_t ac, input mpbs_data_t dc,
                      input mpbs_data_t z);
    chk("main", {15'h0000, main_bank_sel_ff}, 16'(m));
    chk("live", {15'h0000, live_bank_sel_ff}, 16'(l));
    chk("ramp", {15'h0000, alt_ramp_select_ff}, 16'(r));
    chk("accel", accel_time_ff, ac);
    chk("decel", decel_time_ff, dc);
    chk("zero", zero_ff, z);
  endtask

  task automatic report_and_stop;
    if (fails == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    report_and_stop;
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(5'h00, 16'h00FF);
    rd(5'h05, 16'h0000);
    rd(5'h06, 16'h0000);
    wr(5'h00, 16'h0008);
    wr(5'h01, 16'h0053);
    wr(5'h02, 16'h0009);
    for (int i = 0; i < 8; i++) begin
      wr(5'(8 + i), 16'h0011 + 16'(i) + (i >= 4 ? 16'h000C : 16'h0000));
    end
    wr(5'h10, 16'h0031);
    wr(5'h11, 16'h0032);
    rd(5'h0D, 16'h0022);
    set_in(5'h00, 1'b1);
    outs(0, 0, 0, 16'h0011, 16'h0012, 16'h0031);
    set_in(5'h01, 1'b0);
    outs(0, 0, 0, 16'h0011, 16'h0012, 16'h0031);
    // Bank latches one edge after the stop is seen
    @(posedge core_clk);
    want_stop <= 1'b1;
    @(posedge core_clk);
    #1 chk("main early", {15'h0000, main_bank_sel_ff}, 16'h0000);
    @(posedge core_clk);
    #1 chk("main on stop", {15'h0000, main_bank_sel_ff}, 16'h0001);
    set_in(5'h01, 1'b1);
    outs(1, 1, 0, 16'h0021, 16'h0022, 16'h0032);
    set_in(5'h00, 1'b0);
    outs(1, 1, 0, 16'h0021, 16'h0022, 16'h0032);
    set_in(5'h00, 1'b1);
    outs(0, 0, 0, 16'h0011, 16'h0012, 16'h0031);
    set_in(5'h02, 1'b0);
    outs(0, 1, 0, 16'h0021, 16'h0022, 16'h0032);
    rd(5'h12, 16'h0202);
    wr(5'h12, 16'hFFFF);
    rd(5'h12, 16'h0202);
    set_in(5'h04, 1'b0);
    outs(0, 0, 1, 16'h0013, 16'h0014, 16'h0031);
    set_in(5'h00, 1'b0);
    outs(0, 0, 0, 16'h0011, 16'h0012, 16'h0031);
    wr(5'h05, 16'h0001);
    set_in(5'h04, 1'b0);
    outs(0, 0, 0, 16'h0011, 16'h0012, 16'h0031);
    // Last slot and the stopped status bit
    wr(5'h04, 16'h0008);
    set_in(5'h10, 1'b1);
    outs(1, 1, 0, 16'h0021, 16'h0022, 16'h0032);
    rd(5'h12, 16'h100B);
    report_and_stop;
  end
endmodule // mpbs_bank_select_bench

// ===== verif/mpbs_switch_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Switches on the input terminals and the run state
// ----------------------------------------------------------------
module mpbs_switch_model (
  input wire logic core_clk,
  input wire mpbs_pkg::mpbs_term_t want_term,
  input wire logic want_stop,
  output mpbs_pkg::mpbs_term_t terminal_in,
  output logic drive_stopped
);
  import mpbs_pkg::*;
  // Contacts land one clock late; bounce is not modelled
  always_ff @(posedge core_clk) begin
    terminal_in <= want_term;
    drive_stopped <= want_stop;
  end
endmodule // mpbs_switch_model
